/* File: rtl/serial_shift_unit.sv */
// top: control/status register, data shifter and serial pin logic
//
// Chosen here: the register offsets and the plain strobed port.
`timescale 1ns/1ns
module serial_shift_unit (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // register port
    input wire logic [1:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    // serial pins; clock pin enable low while driving
    input wire logic serial_clock_in,
    output logic serial_clock_out,
    output logic serial_clock_oe_n,
    input wire logic serial_input_pin,
    output logic serial_output_pin,
    // completion request to interrupt controller
    output logic completion_irq_flag
);
    typedef struct packed {
        logic [7:0] control;
        logic [7:0] data_upper;
        logic [7:0] data_lower;
        logic level;
        logic overrun;
        logic overrun_seen;
        logic start;
        logic sck;
        logic sck_in_prev;
        logic [4:0] count;
        logic [1:0] tail_count;
        serial_pkg::phase_type phase;
        logic [7:0] rdata;
        logic irq;
    } state_type;

    state_type q, d;
    serial_pkg::bus_req_type req;
    logic half_tick;
    logic int_rise;
    logic int_fall;
    logic ext_rise;
    logic ext_fall;
    logic rise;
    logic fall;
    logic is_ext;
    logic [1:0] mode;
    logic stray_pulse;

    assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};
    assign is_ext = q.control[serial_pkg::ctl_ext];
    assign mode = q.control[serial_pkg::ctl_mode_hi:serial_pkg::ctl_mode_lo];

    // status byte assembly; fixed bits come from the reset pattern
    function automatic logic [7:0] status_byte(input state_type s);
        logic [7:0] v;
        v = serial_pkg::status_fixed;
        v[serial_pkg::st_level] = s.level;
        v[serial_pkg::st_overrun] = s.overrun;
        v[serial_pkg::st_trailer] = (s.phase == serial_pkg::st_tail);
        v[serial_pkg::st_start] = s.start;
        return v;
    endfunction

    serial_prescaler prescaler (
        .clock(clock),
        .rst_n(rst_n),
        .restart(req.wr && req.addr == serial_pkg::addr_status
            && req.wdata[serial_pkg::st_start] && !q.start),
        .select(q.control[2:0]),
        .half_tick(half_tick)
    );

    // internal clock edges from the divider; external taken as synchronous
    assign int_rise = half_tick && !q.sck;
    assign int_fall = half_tick && q.sck;
    assign ext_rise = serial_clock_in && !q.sck_in_prev;
    assign ext_fall = !serial_clock_in && q.sck_in_prev;
    assign rise = is_ext ? ext_rise : int_rise;
    assign fall = is_ext ? ext_fall : int_fall;
    // extra external pulse once the frame is over
    assign stray_pulse = is_ext && !q.start && q.phase == serial_pkg::st_idle && ext_rise;

    always_comb begin
        d = q;
        d.irq = 1'b0;
        d.sck_in_prev = serial_clock_in;
        d.rdata = serial_pkg::zero_byte;
        // internal clock toggles in continuous mode or while busy
        // not in the done state, else a stray clock pulse would follow each frame
        if (!is_ext && (mode == serial_pkg::mode_clock || q.phase == serial_pkg::st_shift
            || q.phase == serial_pkg::st_tail)) begin
            if (half_tick) begin
                d.sck = !q.sck;
            end
        end else begin
            d.sck = 1'b1;
        end
        // shift engine
        case (q.phase)
            serial_pkg::st_idle: begin
                d.count = serial_pkg::count_zero;
            end
            serial_pkg::st_shift: begin
                if (fall) begin
                    // output changes on falling edge, lsb first
                    d.level = q.data_lower[0];
                end
                if (rise) begin
                    if (mode == serial_pkg::mode_16bit) begin
                        d.data_lower = {q.data_upper[0], q.data_lower[7:1]};
                        d.data_upper = {serial_input_pin, q.data_upper[7:1]};
                    end else begin
                        d.data_lower = {serial_input_pin, q.data_lower[7:1]};
                    end
                    d.count = q.count + serial_pkg::count_one;
                    if (q.count + serial_pkg::count_one ==
                        (mode == serial_pkg::mode_16bit ? serial_pkg::bits_16
                                                        : serial_pkg::bits_8)) begin
                        d.start = 1'b0;
                        d.irq = 1'b1;
                        d.tail_count = '0;
                        d.phase = (q.control[serial_pkg::ctl_trailer] && !is_ext)
                            ? serial_pkg::st_tail : serial_pkg::st_done;
                    end
                end
            end
            serial_pkg::st_tail: begin
                // trailer mark: level held latch-high or hold-low for fixed periods
                if (fall) begin
                    d.level = q.control[serial_pkg::ctl_latch];
                end
                if (rise) begin
                    d.tail_count = q.tail_count + 2'h1;
                    if (q.tail_count + 2'h1 == serial_pkg::trailer_periods) begin
                        d.phase = serial_pkg::st_done;
                    end
                end
            end
            serial_pkg::st_done: begin
                d.phase = serial_pkg::st_idle; // level holds last bit, or the latch level after a trailer mark
            end
            default: d.phase = serial_pkg::st_idle;
        endcase
        // extra external pulse after completion
        if (stray_pulse) begin
            d.overrun = 1'b1;
        end
        // register reads: data one cycle later
        if (req.rd) begin
            case (req.addr)
                serial_pkg::addr_control: d.rdata = q.control;
                serial_pkg::addr_status: begin
                    d.rdata = status_byte(q);
                    if (q.overrun) begin
                        d.overrun_seen = 1'b1;
                    end
                end
                serial_pkg::addr_data_upper: d.rdata = q.data_upper;
                serial_pkg::addr_data_lower: d.rdata = q.data_lower;
                default: d.rdata = serial_pkg::zero_byte;
            endcase
        end
        // register writes
        if (req.wr) begin
            case (req.addr)
                serial_pkg::addr_control: begin
                    // writing control aborts any running transfer
                    d.control = req.wdata;
                    d.phase = serial_pkg::st_idle;
                    d.start = 1'b0;
                end
                serial_pkg::addr_status: begin
                    if (q.phase == serial_pkg::st_idle) begin
                        d.level = req.wdata[serial_pkg::st_level];
                    end
                    // set beats clear; clear needs prior read of one
                    if (!req.wdata[serial_pkg::st_overrun] && q.overrun_seen
                        && !stray_pulse) begin
                        d.overrun = 1'b0;
                        d.overrun_seen = 1'b0;
                    end
                    if (req.wdata[serial_pkg::st_start] && !q.start
                        && mode != serial_pkg::mode_clock) begin
                        d.start = 1'b1;
                        d.phase = serial_pkg::st_shift;
                        d.count = serial_pkg::count_zero;
                    end
                end
                serial_pkg::addr_data_upper: d.data_upper = req.wdata;
                serial_pkg::addr_data_lower: d.data_lower = req.wdata;
                default: d.control = q.control;
            endcase
        end
    end

    // all state in one register; data bytes cleared only for tidiness, software must not rely on it
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            q.data_upper <= serial_pkg::zero_byte;
            q.data_lower <= serial_pkg::zero_byte;
            q.control <= serial_pkg::control_reset;
            q.level <= 1'b0;
            q.overrun <= 1'b0;
            q.overrun_seen <= 1'b0;
            q.start <= 1'b0;
            q.sck <= 1'b1;
            q.sck_in_prev <= 1'b1;
            q.count <= serial_pkg::count_zero;
            q.tail_count <= '0;
            q.phase <= serial_pkg::st_idle;
            q.rdata <= serial_pkg::zero_byte;
            q.irq <= 1'b0;
        end else begin
            q <= d;
        end
    end

    // pins straight from flip-flops
    assign rdata = q.rdata;
    assign serial_output_pin = q.level;
    assign serial_clock_out = q.sck;
    assign serial_clock_oe_n = q.control[serial_pkg::ctl_ext];
    assign completion_irq_flag = q.irq;
endmodule

/* File: rtl/serial_pkg.sv */
// package: register map, field positions, reset values and timing for the serial shift unit
// ************************************************************
// Operation
// - control/status resets to 0x9c with pin-level, overrun, trailer, start cleared
// - bit 7 of control/status always reads one and ignores writes
// - bits 4 to 2 ignore writes; read as one, matching reset value
// - pin-level bit reads back the level on the serial output pin
// - writing pin-level bit drives the output pin low or high when idle
// - after a transfer the output pin holds the last transmitted bit, or the latch level after a trailer mark
// - forced level and trailer settings lose effect when a transfer starts
// - external clock: a clock pulse after completion sets the overrun flag
// - overrun clears only by writing zero after reading it as one
// - trailer-active bit reads one only while a trailer mark is sent
// - writing one to start bit begins a transfer except in mode 10; zero does nothing
// - start bit stays set while waiting and shifting, clears on completion
// - 16-bit mode: upper byte shifts into lower, refilled from its msb
// - 8-bit mode: lower byte shifts out lsb first, input enters msb
// - 16-bit mode: received bits enter via the upper byte
// - data bytes are not initialised at reset; cleared to zero here
// - internal clock drives the clock pin; external clock uses it as input
// - mode 10 outputs the prescaled clock continuously on the clock pin
// - lsb first; output changes on falling edge, input sampled on rising
// - mode 00 8-bit, 01 16-bit, 10 continuous clock, 11 reserved
// - clock source select zero internal prescaler, one external clock
// - completion interrupt request flag pulses when a transfer ends
// ************************************************************
package serial_pkg;
    // register addresses
    localparam logic [1:0] addr_control = 2'h0;
    localparam logic [1:0] addr_status = 2'h1;
    localparam logic [1:0] addr_data_upper = 2'h2;
    localparam logic [1:0] addr_data_lower = 2'h3;
    // control register fields
    localparam int ctl_mode_hi = 7;
    localparam int ctl_mode_lo = 6;
    localparam int ctl_trailer = 5;
    localparam int ctl_latch = 4;
    localparam int ctl_ext = 3;
    // status register fields
    localparam int st_level = 6;
    localparam int st_overrun = 5;
    localparam int st_trailer = 1;
    localparam int st_start = 0;
    localparam logic [7:0] control_reset = 8'h00;
    localparam logic [7:0] status_fixed = 8'h9c;
    localparam logic [7:0] zero_byte = 8'h00;
    // mode encodings
    localparam logic [1:0] mode_8bit = 2'h0;
    localparam logic [1:0] mode_16bit = 2'h1;
    localparam logic [1:0] mode_clock = 2'h2;
    // bit counts
    localparam logic [4:0] bits_8 = 5'h08;
    localparam logic [4:0] bits_16 = 5'h10;
    localparam logic [4:0] count_one = 5'h01;
    localparam logic [4:0] count_zero = 5'h00;
    // prescaler width, and trailer mark length in serial clock periods
    localparam int prescale_width = 10;
    localparam logic [1:0] trailer_periods = 2'h2;

    typedef struct packed {
        logic [1:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } bus_req_type;

    typedef enum logic [3:0] {
        st_idle = 4'b0001,
        st_shift = 4'b0010,
        st_tail = 4'b0100,
        st_done = 4'b1000
    } phase_type;
endpackage

/* File: rtl/serial_prescaler.sv */
// prescaler: one-cycle enables for the serial clock half periods
`timescale 1ns/1ns
module serial_prescaler (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // control
    input wire logic restart,
    input wire logic [2:0] select,
    // half-period enable pulse
    output logic half_tick
);
    typedef struct packed {
        logic [serial_pkg::prescale_width-1:0] count;
        logic tick;
    } state_type;

    state_type q, d;

    // division 1024,256,64,32,16,8,4,2 -> half period count minus one
    function automatic logic [serial_pkg::prescale_width-1:0] half_limit(input logic [2:0] s);
        case (s)
            3'h0: half_limit = 10'h1ff;
            3'h1: half_limit = 10'h07f;
            3'h2: half_limit = 10'h01f;
            3'h3: half_limit = 10'h00f;
            3'h4: half_limit = 10'h007;
            3'h5: half_limit = 10'h003;
            3'h6: half_limit = 10'h001;
            default: half_limit = 10'h000;
        endcase
    endfunction

    // free counter, restarted so a new transfer gets full first half period
    always_comb begin
        d = q;
        d.tick = 1'b0;
        if (restart) begin
            d.count = '0;
        end else if (q.count >= half_limit(select)) begin
            d.count = '0;
            d.tick = 1'b1;
        end else begin
            d.count = q.count + 10'h001;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign half_tick = q.tick;
endmodule

/* File: bench/serial_checks_properties.sv */
// checker: port-level properties of the serial shift unit
`timescale 1ns/1ns
module serial_checks (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // register port
    input wire logic [1:0] addr,
    input wire logic wr,
    input wire logic rd,
    input wire logic [7:0] rdata,
    // serial pins and request
    input wire logic serial_clock_out,
    input wire logic serial_clock_oe_n,
    input wire logic serial_output_pin,
    input wire logic completion_irq_flag
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    logic [4:0] rise_q;
    logic sck_q;
    logic st_rd;
    // ************************************************************
    // helper: clock rises since the last register write
    // ************************************************************
    // any write may start or abort a frame, so it restarts the count
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rise_q <= 5'h00;
            sck_q <= 1'b1;
        end else begin
            sck_q <= serial_clock_out;
            if (wr) begin
                rise_q <= 5'h00;
            end else if (serial_clock_out && !sck_q) begin
                rise_q <= rise_q + 5'h01;
            end
        end
    end
    assign st_rd = rd && (addr == serial_pkg::addr_status);
    // ************************************************************
    // properties
    // ************************************************************
    property p_bit7; st_rd |=> rdata[7]; endproperty
    a_bit7: assert property (p_bit7) else $error("status bit 7 read as zero");
    property p_reserved; st_rd |=> rdata[4:2] == 3'h7; endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bits misread");
    property p_level; st_rd |=> rdata[6] == $past(serial_output_pin); endproperty
    a_level: assert property (p_level) else $error("level bit differs from pin");
    property p_trailer; st_rd && serial_clock_oe_n |=> !rdata[1]; endproperty
    a_trailer: assert property (p_trailer) else $error("trailer bit set on external clock");
    property p_irq; completion_irq_flag |=> !completion_irq_flag; endproperty
    a_irq: assert property (p_irq) else $error("completion request too long");
    // on the internal clock, outside register writes the data pin moves only with a clock fall
    property p_fall;
        $changed(serial_output_pin) && !serial_clock_oe_n && !$past(wr) && !$past(wr, 2)
            |-> $fell(serial_clock_out);
    endproperty
    a_fall: assert property (p_fall) else $error("data pin moved off a clock fall");
    property p_count;
        completion_irq_flag && !serial_clock_oe_n
            |-> (rise_q + {4'h0, serial_clock_out && !sck_q}) inside {5'h08, 5'h10};
    endproperty
    a_count: assert property (p_count) else $error("frame length not 8 or 16");
    property p_hold;
        completion_irq_flag && serial_clock_oe_n && !wr ##1 !wr |=> $stable(serial_output_pin);
    endproperty
    a_hold: assert property (p_hold) else $error("data pin moved after frame");
    c_int_done: cover property (completion_irq_flag && !serial_clock_oe_n);
    c_ext_done: cover property (completion_irq_flag && serial_clock_oe_n);
    c_status_rd: cover property (st_rd);
endmodule
bind serial_shift_unit serial_checks i_serial_checks (
    .clock(clock), .rst_n(rst_n), .addr(addr), .wr(wr), .rd(rd), .rdata(rdata),
    .serial_clock_out(serial_clock_out), .serial_clock_oe_n(serial_clock_oe_n),
    .serial_output_pin(serial_output_pin), .completion_irq_flag(completion_irq_flag)
);

/* File: bench/serial_peer.sv */
// peer model: external serial device on the clock, data-in and data-out wires
`timescale 1ns/1ns
module serial_peer (
    // serial wires
    input wire logic sck,
    input wire logic so,
    output logic si,
    // bench side
    input wire logic arm,
    input wire logic [4:0] nbits,
    input wire logic [15:0] send_word,
    output logic [15:0] got_word,
    output logic [4:0] rises
);
    logic [4:0] sent;
    initial begin
        si = 1'b0;
        sent = 5'h00;
        rises = 5'h00;
        got_word = 16'h0000;
    end
    // frame counters restart before each armed transfer
    always @(posedge arm) begin
        sent = 5'h00;
        rises = 5'h00;
    end
    // sample device data on each rise, lsb first
    always @(posedge sck) begin
        got_word = {so, got_word[15:1]};
        rises = rises + 5'h01;
    end
    // next bit on each fall; past the frame the line toggles, no stale level
    always @(negedge sck) begin
        si = (sent < nbits) ? send_word[sent[3:0]] : ~si;
        sent = sent + 5'h01;
    end
endmodule

/* File: bench/testbench.sv */
// testbench: register tasks, peer model and scenarios for the serial shift unit
`timescale 1ns/1ns
`define CHK(nm, exp, got) begin compares++; if ((got) !== (exp)) begin n_errors++; \
    $display("ERROR %s expected %h seen %h", nm, exp, got); end end
module testbench;
    localparam logic [1:0] a_ctl = serial_pkg::addr_control;
    localparam logic [1:0] a_st = serial_pkg::addr_status;
    localparam logic [1:0] a_up = serial_pkg::addr_data_upper;
    localparam logic [1:0] a_lo = serial_pkg::addr_data_lower;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic [1:0] addr = 2'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic serial_clock_in = 1'b1;
    logic arm = 1'b0;
    logic [4:0] nbits = 5'h08;
    logic [15:0] send_word = 16'h0000;
    logic [7:0] rdata, s;
    logic serial_clock_out, serial_clock_oe_n, serial_input_pin, serial_output_pin;
    logic completion_irq_flag, sck;
    logic [15:0] got_word;
    logic [4:0] rises;
    int n_errors = 0;
    int compares = 0;
    int irqs = 0;
    // ************************************************************
    // clock, wires and instances
    // ************************************************************
    always #50 clock = ~clock;
    // the clock wire follows whichever side drives it
    assign sck = serial_clock_oe_n ? serial_clock_in : serial_clock_out;
    always @(posedge clock) if (completion_irq_flag === 1'b1) irqs++;
    serial_shift_unit i_serial_shift_unit (.clock(clock), .rst_n(rst_n), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .serial_clock_in(serial_clock_in),
        .serial_clock_out(serial_clock_out), .serial_clock_oe_n(serial_clock_oe_n),
        .serial_input_pin(serial_input_pin), .serial_output_pin(serial_output_pin),
        .completion_irq_flag(completion_irq_flag));
    serial_peer i_serial_peer (.sck(sck), .so(serial_output_pin), .si(serial_input_pin),
        .arm(arm), .nbits(nbits), .send_word(send_word), .got_word(got_word), .rises(rises));
    // ************************************************************
    // tasks
    // ************************************************************
    task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
        // let the edge that takes the write settle before anyone looks
        #1;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [1:0] a);
        @(posedge clock);
        addr <= a;
        rd <= 1'b1;
        @(posedge clock);
        rd <= 1'b0;
        #1;
        s = rdata;
    endtask
    task automatic frame(input logic [4:0] n, input logic [15:0] w);
        @(posedge clock);
        arm <= 1'b1;
        nbits <= n;
        send_word <= w;
        @(posedge clock);
        arm <= 1'b0;
    endtask
    // external clock stands high between frames
    task automatic ext_pulses(input int n);
        repeat (n) begin
            @(posedge clock) serial_clock_in <= 1'b0;
            repeat (4) @(posedge clock);
            serial_clock_in <= 1'b1;
            repeat (4) @(posedge clock);
        end
    endtask
    task automatic results;
        if (n_errors == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic wait_irq(input int want);
        for (int i = 0; i < 2000 && irqs < want; i++) begin
            @(posedge clock);
        end
        if (irqs < want) begin
            n_errors++;
            results();
        end
    endtask
    // ************************************************************
    // scenarios
    // ************************************************************
    initial begin
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        rd_reg(a_st);
        `CHK("status reset", 8'h9c, s)
        // fixed, overrun, trailer and start bits ignore this write
        wr_reg(a_st, 8'h62);
        rd_reg(a_st);
        `CHK("status after write", 8'hdc, s)
        `CHK("pin forced high", 1'b1, serial_output_pin)
        // 8-bit frame on the internal clock; last bit zero overrides forced level
        wr_reg(a_ctl, 8'h07);
        `CHK("clock pin driven", 1'b0, serial_clock_oe_n)
        wr_reg(a_lo, 8'h25);
        frame(5'h08, 16'h003c);
        wr_reg(a_st, 8'h01);
        rd_reg(a_st);
        `CHK("busy flag", 1'b1, s[0])
        wait_irq(1);
        `CHK("tx byte", 8'h25, got_word[15:8])
        `CHK("rises 8", 5'h08, rises)
        rd_reg(a_lo);
        `CHK("rx byte", 8'h3c, s)
        rd_reg(a_st);
        `CHK("status after frame", 8'h9c, s)
        wr_reg(a_st, 8'h40);
        `CHK("pin set high", 1'b1, serial_output_pin)
        // 16-bit frame: lower byte leaves first, input refills through upper
        wr_reg(a_ctl, 8'h47);
        wr_reg(a_up, 8'h12);
        wr_reg(a_lo, 8'h34);
        frame(5'h10, 16'hbeef);
        wr_reg(a_st, 8'h01);
        wait_irq(2);
        `CHK("tx word", 16'h1234, got_word)
        `CHK("rises 16", 5'h10, rises)
        rd_reg(a_lo);
        `CHK("rx lower", 8'hef, s)
        rd_reg(a_up);
        `CHK("rx upper", 8'hbe, s)
        // trailer mark, latch level, divide by 16 so the mark lasts long enough to read
        wr_reg(a_ctl, 8'h34);
        wr_reg(a_lo, 8'h00);
        wr_reg(a_st, 8'h01);
        wait_irq(3);
        rd_reg(a_st);
        `CHK("trailer active", 2'b10, s[1:0])
        repeat (60) @(posedge clock);
        rd_reg(a_st);
        `CHK("after trailer", 8'hdc, s)
        // external clock, then one stray pulse after the frame
        wr_reg(a_ctl, 8'h08);
        `CHK("clock pin input", 1'b1, serial_clock_oe_n)
        wr_reg(a_lo, 8'h81);
        frame(5'h08, 16'h00a6);
        wr_reg(a_st, 8'h01);
        ext_pulses(8);
        wait_irq(4);
        `CHK("ext tx byte", 8'h81, got_word[15:8])
        ext_pulses(1);
        // a zero written before the flag was read must not clear it
        wr_reg(a_st, 8'h00);
        rd_reg(a_st);
        `CHK("overrun set", 2'b10, {s[5], s[0]})
        wr_reg(a_st, 8'h80);
        rd_reg(a_st);
        `CHK("overrun cleared", 1'b0, s[5])
        rd_reg(a_lo);
        `CHK("ext rx byte", 8'ha6, s)
        // continuous clock mode refuses a start yet runs the clock
        wr_reg(a_ctl, 8'h87);
        wr_reg(a_st, 8'h01);
        frame(5'h00, 16'h0000);
        repeat (20) @(posedge clock);
        `CHK("continuous clock", 1'b1, rises > 5'h04)
        rd_reg(a_st);
        `CHK("start refused", 1'b0, s[0])
        results();
    end
endmodule
